// ===== dv/msg_framer_props.sv
// Port checker for the message framer
`timescale 1ns/1ps
`default_nettype none
module msg_framer_props
  import msg_pkg::*;
(
  // Watched ports
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready, tx_valid, tx_ready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  tx_byte
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Byte position in the outgoing frame
  logic [8:0] idx;
  logic [7:0] blen;
  wire        tk = tx_valid && tx_ready;
  always_ff @(posedge aclk)
    if (!aresetn) idx <= '0;
    else if (tk) idx <= (idx == 9'h01F + blen) ? '0 : idx + 9'h001;
  always_ff @(posedge aclk)
    if (!aresetn) blen <= '0;
    else if (tk && idx == 9'h008) blen <= tx_byte;
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  b_wait_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  r_wait_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("tx byte dropped");
  sync_one_a: assert property (tk && idx == 9'h000 |-> tx_byte == sync_first)
    else $error("first sync wrong");
  sync_rest_a: assert property (tk && idx > 9'h000 && idx < 9'h003
    |-> tx_byte == (idx == 9'h001 ? sync_second : sync_third)) else $error("sync wrong");
  hdr_len_a: assert property (tk && idx == 9'h003 |-> tx_byte == base_header_len)
    else $error("header length wrong");
  port_code_a: assert property (tk && idx == 9'h007 |-> tx_byte == current_port_code)
    else $error("port byte wrong");
  zero_field_a: assert property (tk && idx > 9'h008 && idx < 9'h01C |-> tx_byte == zero_byte)
    else $error("header field not zero");
  cover property (tk && idx == 9'h000);
  cover property (tx_valid && !tx_ready);
  cover property (s_axi_bvalid && s_axi_bresp == resp_slverr);
endmodule // msg_framer_props
bind msg_framer msg_framer_props msg_framer_props_i (.*);
`default_nettype wire

// ===== dv/rx_model.sv
// Receiver model: takes frames, checks them, echoes them back
`timescale 1ns/1ps
`default_nettype none
module rx_model
  import msg_pkg::*;
(
  input wire logic       aclk, tx_valid, bad,
  input wire logic [7:0] tx_byte,
  output logic           tx_ready, rx_valid,
  output logic     [7:0] rx_byte,
  output int             errs
);
  logic [7:0]  m [0:299];
  logic [31:0] c;
  int          n;
  function automatic logic [31:0] crc(input logic [31:0] s, input logic [7:0] b);
    s ^= 32'(b);
    repeat (8) s = s[0] ? (s >> 1) ^ 32'hEDB8_8320 : s >> 1;
    return s;
  endfunction
  initial
  begin
    {tx_ready, rx_valid, rx_byte} = '0;
    errs = 0;
    forever
    begin
      n = 0;
      while (n < 9 || n < 32 + m[8])
      begin
        @(posedge aclk);
        if (tx_valid && tx_ready) m[n++] = tx_byte;
        // Stall until a byte is offered, so the hold check gets exercised
        tx_ready <= (n % 3 != 1) || (tx_valid && !tx_ready);
      end
      c = '0;
      for (int i = 0; i < n - 4; i++) c = crc(c, m[i]);
      if (m[0] != sync_first || m[1] != sync_second || m[2] != sync_third
          || c != {m[n-1], m[n-2], m[n-3], m[n-4]}) errs++;
      // reply mirrors the request, sequence zero
      for (int i = -1; i < n; i++)
      begin
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_byte <= i < 0 ? 8'h55 : (i == n - 1 && bad ? ~m[i] : m[i]);
      end
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
    end
  end
endmodule // rx_model
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench for the message framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top
  import msg_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1, bad = 1'b0;
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, d, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        tx_valid, tx_ready, rx_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  tx_byte, rx_byte;
  int          err_count = 0, samples_checked = 0, errs;
  always #25 aclk = ~aclk;
  msg_framer msg_framer_i (.*);
  rx_model rx_model_i (.*);
  task automatic final_report;
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A bound ran out: count it and close
  task automatic tick(inout int k);
    @(posedge aclk);
    if (++k > 300)
    begin
      err_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] e);
    int k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      tick(k);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK("bresp", e, s_axi_bresp)
  endtask
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] m, x);
    int k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      tick(k);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    `CHK("rresp", resp_okay, s_axi_rresp)
    if (m != '0) `CHK(n, x, d & m)
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("status", reg_status, 32'hFFFF_FFFF, 32'h0000_0500);
    wr(6'h3C, 32'h0000_0000, resp_slverr);
    // Every format code, last one with a broken trailer
    for (int f = 0; f < 4; f++)
    begin
      bad <= f == 3;
      wr(reg_tx_id, 32'h0001_1234 + f, resp_okay);
      wr(reg_ctrl, 32'h0000_0002, resp_okay);
      wr(reg_tx_data, 32'h0000_005A + f, resp_okay);
      wr(reg_ctrl, {16'h0000, f[0], f[1:0], 5'h03, 8'h01}, resp_okay);
      d = '0;
      for (int j = 0; j < 200 && d[1:0] == 2'b00; j++) rd("poll", reg_status, '0, '0);
      if (d[1:0] == 2'b00)
      begin
        err_count++;
        final_report();
      end
      rd("status", reg_status, f < 3 ? 32'h0000_0F83 : 32'h0000_0003,
         f < 3 ? {20'h0_0000, 3'b100, f == 0, f[0], 5'h00, 2'b01} : 32'h0000_0002);
      if (f < 3)
      begin
        rd("rx id", reg_rx_id, 32'h0000_FFFF, 32'h0000_1234 + f);
        rd("rx hdr", reg_rx_hdr, 32'hFFFF_FFFF, {16'h0000, 8'hC0, f[0], f[1:0], 5'h03});
        rd("rx body", reg_rx_data, 32'h0000_00FF, 32'h0000_005A + f);
      end
      wr(reg_status, 32'h0000_0003, resp_okay);
    end
    rd("counts", reg_counts, 32'hFFFF_FFFF, 32'h0001_0003);
    `CHK("model", 0, errs)
    final_report();
  end
endmodule // tb_top
`default_nettype wire

// ===== logic/body_ram.sv
// Small byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module body_ram
  import msg_pkg::*;
(
  // Clock
  input wire logic   aclk,
  // Port
  byte_buf_if.mem    bus
);
  logic [7:0] mem [0:(1<<body_aw)-1];
  always_ff @(posedge aclk)
  begin
    if (bus.we)
    begin
      mem[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.raddr];
  end
endmodule : body_ram
`default_nettype wire

// ===== logic/byte_buf_if.sv
// Interface: byte memory port between framer and its body buffer
`timescale 1ns/1ps
`default_nettype none
interface byte_buf_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport user (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : byte_buf_if
`default_nettype wire

// ===== logic/crc32_step.sv
// Byte-wide CRC accumulator; polynomial is a parameter
`timescale 1ns/1ps
`default_nettype none
module crc32_step
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Control
  input wire logic        clear,
  input wire logic        en,
  input wire logic [7:0]  data,
  // Result
  output logic     [31:0] crc
);
  // Polynomial and seed are not fixed here; plain reflected defaults
  parameter logic [31:0] POLY = 32'hEDB8_8320;
  parameter logic [31:0] SEED = 32'h0000_0000;
  logic [31:0] next_crc;
  always_comb
  begin
    next_crc = crc ^ {24'h00_0000, data};
    for (int i = 0; i < 8; i++)
    begin
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ POLY) : (next_crc >> 1);
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      crc <= SEED;
    end
    else if (en)
    begin
      crc <= next_crc;
    end
  end
endmodule : crc32_step
`default_nettype wire

// ===== logic/msg_framer.sv
// Host-side binary message framer and parser with AXI4-Lite control
// Overview of operation
// - Sync bytes AA 44 12 lead messages
// - Locate body by header length field
// - Four-byte CRC over all preceding bytes
// - Offset 3 holds header length
// - Offsets 4-5 hold message identifier
// - Byte 6: source, format, response bit
// - Format 00 binary, 01 ASCII, 10 abbrev
// - Byte 7 holds low port bits
// - Host sends current port code 192
// - Offsets 8-9 hold body length
// - Time status is one byte at 13
// - Week at 14, milliseconds at 16
// - Group codes 0,1-3,6,8 decoded
// - Further group codes 7, 9-10, 13-17, 19-21 decoded
`timescale 1ns/1ps
`default_nettype none
module msg_framer
  import msg_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // AXI4-Lite write address
  input wire logic        s_axi_awvalid,
  output logic            s_axi_awready,
  input wire logic [5:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic        s_axi_wvalid,
  output logic            s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic            s_axi_bvalid,
  input wire logic        s_axi_bready,
  output logic     [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input wire logic        s_axi_arvalid,
  output logic            s_axi_arready,
  input wire logic [5:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic            s_axi_rvalid,
  input wire logic        s_axi_rready,
  output logic     [31:0] s_axi_rdata,
  output logic     [1:0]  s_axi_rresp,
  // Byte stream to receiver
  output logic            tx_valid,
  input wire logic        tx_ready,
  output logic     [7:0]  tx_byte,
  // Byte stream from receiver
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_byte
);
  typedef enum {tx_idle, tx_hdr, tx_body, tx_crc} tx_state_e;
  typedef enum {rx_hunt, rx_s1, rx_s2, rx_hdr, rx_body, rx_crc} rx_state_e;
  // =====================================================
  // Control registers
  logic [15:0] tx_id;
  logic [15:0] tx_len;
  logic [1:0]  tx_fmt;
  logic        tx_resp;
  logic [4:0]  tx_src;
  logic        tx_busy;
  logic [7:0]  tx_wptr;
  logic        rx_done;
  logic        rx_bad;
  logic [15:0] good_cnt;
  logic [15:0] bad_cnt;
  // =====================================================
  // Body buffers
  byte_buf_if txb ();
  byte_buf_if rxb ();
  body_ram u_tx_ram (.aclk(aclk), .bus(txb.mem));
  body_ram u_rx_ram (.aclk(aclk), .bus(rxb.mem));
  // =====================================================
  // AXI write path
  logic aw_hold, w_hold;
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;
  wire wr_ctrl  = do_write && (aw_addr == reg_ctrl);
  wire wr_id    = do_write && (aw_addr == reg_tx_id);
  wire wr_data  = do_write && (aw_addr == reg_tx_data);
  wire wr_stat  = do_write && (aw_addr == reg_status);
  wire wr_known = wr_ctrl || wr_id || wr_data || wr_stat;
  wire start_tx = wr_ctrl && w_strb[0] && w_data[0] && !tx_busy;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 6'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? resp_okay : resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  // =====================================================
  // Message parameters written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_id   <= 16'h0000;
      tx_len  <= 16'h0000;
      tx_fmt  <= fmt_binary;
      tx_resp <= 1'b0;
      tx_src  <= 5'h00;
      tx_wptr <= 8'h00;
    end
    else
    begin
      if (wr_id)
      begin
        tx_id  <= w_data[15:0];
        tx_len <= {8'h00, w_data[23:16]};
      end
      if (wr_ctrl)
      begin
        tx_src  <= w_data[12:8];
        tx_fmt  <= w_data[14:13];
        tx_resp <= w_data[15];
        if (w_data[1])
        begin
          tx_wptr <= 8'h00;
        end
      end
      else if (wr_data)
      begin
        tx_wptr <= tx_wptr + 8'h01;
      end
    end
  end
  assign txb.we    = wr_data;
  assign txb.waddr = tx_wptr;
  assign txb.wdata = w_data[7:0];
  // =====================================================
  // Transmit framer
  tx_state_e   tx_state;
  logic [7:0]  tx_cnt;
  logic [7:0]  hdr_byte;
  logic [31:0] tx_crc_val;
  wire tx_fire = tx_valid && tx_ready;
  wire [7:0] tx_type = {tx_resp, tx_fmt, tx_src};
  assign hdr_byte =
    (tx_cnt == 8'h00)           ? sync_first :
    (tx_cnt == 8'h01)           ? sync_second :
    (tx_cnt == 8'h02)           ? sync_third :
    (tx_cnt == off_header_len)  ? base_header_len :
    (tx_cnt == off_msg_id)      ? tx_id[7:0] :
    (tx_cnt == off_msg_id + 8'h01) ? tx_id[15:8] :
    (tx_cnt == off_msg_type)    ? tx_type :
    (tx_cnt == off_port)        ? current_port_code :
    (tx_cnt == off_body_len)    ? tx_len[7:0] :
    (tx_cnt == off_body_len + 8'h01) ? tx_len[15:8] :
    zero_byte;
  crc32_step u_tx_crc (
    .aclk(aclk), .aresetn(aresetn), .clear(start_tx),
    .en(tx_fire && tx_state != tx_crc), .data(tx_byte), .crc(tx_crc_val));
  wire [7:0] crc_sel = tx_crc_val[{tx_cnt[1:0], 3'b000} +: 8];
  // Reads run one byte ahead; byte 0 is fetched while the header goes out
  assign txb.raddr = (tx_state != tx_body) ? 8'h00 : tx_fire ? tx_cnt + 8'h01 : tx_cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= tx_idle;
      tx_cnt   <= 8'h00;
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
      tx_busy  <= 1'b0;
    end
    else
    begin
      case (tx_state)
        tx_idle:
          if (start_tx)
          begin
            tx_state <= tx_hdr;
            tx_busy  <= 1'b1;
            tx_cnt   <= 8'h00;
          end
        tx_hdr:
          if (!tx_valid)
          begin
            tx_valid <= 1'b1;
            tx_byte  <= hdr_byte;
          end
          else if (tx_fire)
          begin
            tx_valid <= 1'b0;
            if (tx_cnt == base_header_len - 8'h01)
            begin
              tx_cnt   <= 8'h00;
              tx_state <= (tx_len == 16'h0000) ? tx_crc : tx_body;
            end
            else
            begin
              tx_cnt <= tx_cnt + 8'h01;
            end
          end
        tx_body:
          if (!tx_valid)
          begin
            tx_valid <= 1'b1;
            tx_byte  <= txb.rdata;
          end
          else if (tx_fire)
          begin
            tx_valid <= 1'b0;
            if ({8'h00, tx_cnt} == tx_len - 16'h0001)
            begin
              tx_cnt   <= 8'h00;
              tx_state <= tx_crc;
            end
            else
            begin
              tx_cnt <= tx_cnt + 8'h01;
            end
          end
        tx_crc:
          if (!tx_valid)
          begin
            tx_valid <= 1'b1;
            tx_byte  <= crc_sel;
          end
          else if (tx_fire)
          begin
            tx_valid <= 1'b0;
            tx_cnt   <= tx_cnt + 8'h01;
            if (tx_cnt == {5'h00, crc_bytes} - 8'h01)
            begin
              tx_state <= tx_idle;
              tx_busy  <= 1'b0;
            end
          end
        default:
          tx_state <= tx_idle;
      endcase
    end
  end
  // =====================================================
  // Receive parser
  rx_state_e   rx_state;
  logic [7:0]  rx_cnt;
  logic [15:0] rx_cnt16;
  logic [7:0]  rx_hlen;
  logic [15:0] rx_id;
  logic [7:0]  rx_type;
  logic [7:0]  rx_port;
  logic [15:0] rx_blen;
  logic [15:0] rx_seq;
  logic [7:0]  rx_tstat;
  logic [15:0] rx_week;
  logic [31:0] rx_ms;
  logic [31:0] rx_trail;
  logic [31:0] rx_crc_val;
  wire rx_hit_first = rx_valid && (rx_byte == sync_first);
  wire rx_in_msg = rx_state != rx_hunt && rx_state != rx_crc;
  // The first sync byte must enter the crc, so it overrides the hunt clear
  crc32_step u_rx_crc (
    .aclk(aclk), .aresetn(aresetn), .clear(rx_state == rx_hunt && !rx_hit_first),
    .en(rx_valid && (rx_in_msg || rx_hit_first)), .data(rx_byte), .crc(rx_crc_val));
  assign rxb.we    = rx_valid && rx_state == rx_body;
  assign rxb.waddr = rx_cnt16[7:0];
  assign rxb.wdata = rx_byte;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state <= rx_hunt;
      rx_cnt <= 8'h00; rx_cnt16 <= 16'h0000; rx_hlen <= 8'h00;
      rx_id <= 16'h0000; rx_type <= 8'h00; rx_port <= 8'h00;
      rx_blen <= 16'h0000; rx_seq <= 16'h0000; rx_tstat <= 8'h00;
      rx_week <= 16'h0000; rx_ms <= 32'h0000_0000; rx_trail <= 32'h0000_0000;
    end
    else if (rx_valid)
    begin
      case (rx_state)
        rx_hunt:
          if (rx_hit_first) rx_state <= rx_s1;
        rx_s1:
          rx_state <= (rx_byte == sync_second) ? rx_s2 :
                      (rx_byte == sync_first) ? rx_s1 : rx_hunt;
        rx_s2:
          if (rx_byte == sync_third)
          begin
            rx_state <= rx_hdr;
            rx_cnt   <= off_header_len;
          end
          else
          begin
            rx_state <= rx_hunt;
          end
        rx_hdr:
        begin
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt == off_header_len) rx_hlen <= rx_byte;
          if (rx_cnt == off_msg_id) rx_id[7:0] <= rx_byte;
          if (rx_cnt == off_msg_id + 8'h01) rx_id[15:8] <= rx_byte;
          if (rx_cnt == off_msg_type) rx_type <= rx_byte;
          if (rx_cnt == off_port) rx_port <= rx_byte;
          if (rx_cnt == off_body_len) rx_blen[7:0] <= rx_byte;
          if (rx_cnt == off_body_len + 8'h01) rx_blen[15:8] <= rx_byte;
          if (rx_cnt == off_sequence) rx_seq[7:0] <= rx_byte;
          if (rx_cnt == off_sequence + 8'h01) rx_seq[15:8] <= rx_byte;
          if (rx_cnt == off_time_status) rx_tstat <= rx_byte;
          if (rx_cnt == off_week) rx_week[7:0] <= rx_byte;
          if (rx_cnt == off_week + 8'h01) rx_week[15:8] <= rx_byte;
          if (rx_cnt >= off_week_ms && rx_cnt < off_rx_status)
            rx_ms[{rx_cnt[1:0], 3'b000} +: 8] <= rx_byte;
          if (rx_cnt > off_header_len && rx_cnt == rx_hlen - 8'h01)
          begin
            rx_cnt16 <= 16'h0000;
            rx_state <= (rx_blen == 16'h0000) ? rx_crc : rx_body;
            rx_cnt   <= 8'h00;
          end
        end
        rx_body:
        begin
          rx_cnt16 <= rx_cnt16 + 16'h0001;
          if (rx_cnt16 == rx_blen - 16'h0001) rx_state <= rx_crc;
        end
        rx_crc:
        begin
          rx_trail[{rx_cnt[1:0], 3'b000} +: 8] <= rx_byte;
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt == {5'h00, crc_bytes} - 8'h01) rx_state <= rx_hunt;
        end
        default:
          rx_state <= rx_hunt;
      endcase
    end
  end
  wire rx_end = rx_valid && rx_state == rx_crc && rx_cnt == {5'h00, crc_bytes} - 8'h01;
  wire [31:0] rx_trail_full = {rx_byte, rx_trail[23:0]};
  wire rx_crc_ok = rx_trail_full == rx_crc_val;
  wire rx_fmt_bin = rx_type[fmt_msb:fmt_lsb] == fmt_binary;
  wire rx_port_wide = rx_port >= port_wide_lo && rx_port <= port_wide_hi;
  wire rx_port_group =
    rx_port == no_ports || rx_port == serial_one_group || rx_port == serial_two_group ||
    rx_port == serial_three_group || rx_port == current_port_group ||
    rx_port == file_group || rx_port == all_ports_group ||
    rx_port == extended_one_group || rx_port == extended_two_group ||
    rx_port == usb_first_group || rx_port == usb_second_group ||
    rx_port == usb_third_group || rx_port == auxiliary_group ||
    rx_port == extended_three_group || rx_port == serial_four_group ||
    rx_port == ethernet_group || rx_port == inertial_unit_group;
  wire rx_port_single = rx_port >= port_min_single;
  // =====================================================
  // Status flags; set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_done <= 1'b0;
      rx_bad  <= 1'b0;
      good_cnt <= 16'h0000;
      bad_cnt  <= 16'h0000;
    end
    else
    begin
      if (rx_end && rx_crc_ok) rx_done <= 1'b1;
      else if (wr_stat && w_data[0]) rx_done <= 1'b0;
      if (rx_end && !rx_crc_ok) rx_bad <= 1'b1;
      else if (wr_stat && w_data[1]) rx_bad <= 1'b0;
      if (rx_end && rx_crc_ok) good_cnt <= good_cnt + 16'h0001;
      if (rx_end && !rx_crc_ok) bad_cnt <= bad_cnt + 16'h0001;
    end
  end
  // =====================================================
  // AXI read path
  logic       ar_hold;
  logic [5:0] ar_addr;
  logic [7:0] rx_rptr;
  assign rxb.raddr = rx_rptr;
  wire [31:0] status_word = {20'h0_0000, rx_port_single, rx_port_group, rx_port_wide,
                             rx_fmt_bin, rx_type[resp_bit], 1'b0, tx_busy,
                             3'h0, rx_bad, rx_done};
  wire rd_known = ar_addr <= reg_crc && ar_addr[1:0] == 2'b00;
  wire [31:0] rd_word =
    (ar_addr == reg_ctrl)    ? {16'h0000, tx_resp, tx_fmt, tx_src, 8'h00} :
    (ar_addr == reg_status)  ? status_word :
    (ar_addr == reg_tx_id)   ? {8'h00, tx_len[7:0], tx_id} :
    (ar_addr == reg_rx_id)   ? {rx_blen, rx_id} :
    (ar_addr == reg_rx_hdr)  ? {rx_seq, rx_port, rx_type} :
    (ar_addr == reg_rx_time) ? {8'h00, rx_tstat, rx_week} :
    (ar_addr == reg_rx_ms)   ? rx_ms :
    (ar_addr == reg_rx_data) ? {24'h00_0000, rxb.rdata} :
    (ar_addr == reg_counts)  ? {bad_cnt, good_cnt} :
    (ar_addr == reg_crc)     ? rx_crc_val :
    32'h0000_0000;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_hold <= 1'b0;
      ar_addr <= 6'h00;
      rx_rptr <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_hold <= 1'b1;
        ar_addr <= s_axi_araddr;
      end
      if (ar_hold && !s_axi_rvalid)
      begin
        ar_hold <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? resp_okay : resp_slverr;
        if (ar_addr == reg_rx_data) rx_rptr <= rx_rptr + 8'h01;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
      if (rx_end) rx_rptr <= 8'h00;
    end
  end
  assign s_axi_arready = !ar_hold && !s_axi_rvalid;
endmodule : msg_framer
`default_nettype wire

// ===== logic/msg_pkg.sv
// Package: constants for the binary message framer controller
package msg_pkg;
  // =====================================================
  // Sync pattern and header layout
  localparam logic [7:0] sync_first        = 8'hAA;
  localparam logic [7:0] sync_second       = 8'h44;
  localparam logic [7:0] sync_third        = 8'h12;
  localparam logic [7:0] base_header_len   = 8'h1C;
  localparam logic [7:0] off_header_len    = 8'h03;
  localparam logic [7:0] off_msg_id        = 8'h04;
  localparam logic [7:0] off_msg_type      = 8'h06;
  localparam logic [7:0] off_port          = 8'h07;
  localparam logic [7:0] off_body_len      = 8'h08;
  localparam logic [7:0] off_sequence      = 8'h0A;
  localparam logic [7:0] off_idle          = 8'h0C;
  localparam logic [7:0] off_time_status   = 8'h0D;
  localparam logic [7:0] off_week          = 8'h0E;
  localparam logic [7:0] off_week_ms       = 8'h10;
  localparam logic [7:0] off_rx_status     = 8'h14;
  localparam logic [7:0] off_reserved      = 8'h18;
  localparam logic [7:0] off_build         = 8'h1A;
  localparam logic [2:0] crc_bytes         = 3'h4;
  // =====================================================
  // Message type fields
  localparam int         src_lsb           = 0;
  localparam int         src_msb           = 4;
  localparam int         fmt_lsb           = 5;
  localparam int         fmt_msb           = 6;
  localparam int         resp_bit          = 7;
  localparam logic [1:0] fmt_binary        = 2'h0;
  localparam logic [1:0] fmt_ascii         = 2'h1;
  localparam logic [1:0] fmt_abbrev        = 2'h2;
  localparam logic [1:0] fmt_reserved      = 2'h3;
  // =====================================================
  // Port codes
  localparam logic [7:0] current_port_code = 8'hC0;
  localparam logic [7:0] port_wide_lo      = 8'hA0;
  localparam logic [7:0] port_wide_hi      = 8'hBF;
  localparam logic [7:0] port_min_single   = 8'h20;
  localparam logic [7:0] no_ports          = 8'h00;
  localparam logic [7:0] serial_one_group  = 8'h01;
  localparam logic [7:0] serial_two_group  = 8'h02;
  localparam logic [7:0] serial_three_group = 8'h03;
  localparam logic [7:0] current_port_group = 8'h06;
  localparam logic [7:0] file_group        = 8'h07;
  localparam logic [7:0] all_ports_group   = 8'h08;
  localparam logic [7:0] extended_one_group = 8'h09;
  localparam logic [7:0] extended_two_group = 8'h0A;
  localparam logic [7:0] usb_first_group   = 8'h0D;
  localparam logic [7:0] usb_second_group  = 8'h0E;
  localparam logic [7:0] usb_third_group   = 8'h0F;
  localparam logic [7:0] auxiliary_group   = 8'h10;
  localparam logic [7:0] extended_three_group = 8'h11;
  localparam logic [7:0] serial_four_group = 8'h13;
  localparam logic [7:0] ethernet_group    = 8'h14;
  localparam logic [7:0] inertial_unit_group = 8'h15;
  // =====================================================
  // Control register map (word aligned)
  localparam logic [5:0] reg_ctrl          = 6'h00;
  localparam logic [5:0] reg_status        = 6'h04;
  localparam logic [5:0] reg_tx_id         = 6'h08;
  localparam logic [5:0] reg_tx_data       = 6'h0C;
  localparam logic [5:0] reg_rx_id         = 6'h10;
  localparam logic [5:0] reg_rx_hdr        = 6'h14;
  localparam logic [5:0] reg_rx_time       = 6'h18;
  localparam logic [5:0] reg_rx_ms         = 6'h1C;
  localparam logic [5:0] reg_rx_data       = 6'h20;
  localparam logic [5:0] reg_counts        = 6'h24;
  localparam logic [5:0] reg_crc           = 6'h28;
  localparam logic [1:0] resp_okay         = 2'h0;
  localparam logic [1:0] resp_slverr       = 2'h2;
  localparam int         body_aw           = 8;
  localparam logic [7:0] zero_byte         = 8'h00;
endpackage : msg_pkg
